// *** core/eas_pkg.sv ***
// ****************************************************************
// Overview of operation
// (R1) A true event runs the action of the same index, then advances
// (R2) Only the event at the current index is evaluated per scan
// (R3) A false event runs nothing and keeps the index until next scan
// (R4) Start at slot zero and re-check only that event until true
// (R5) Programmed pair count is one to twenty; only those slots used
// (R6) After the last configured pair the index wraps to slot zero
// (R7) Comparators test a selected operand against a preset value
// (R8) Logic rules combine up to three boolean inputs with AND, OR, NOT
// (R9) Event source selects a status bit, a logic rule or a comparator
// (R10) Rule and comparator outputs stay valid outside the sequence
// (R11) Evaluation only on scan tick; synchronous clear resets index
// ****************************************************************
package eas_pkg;
   localparam int EAS_MAX_SLOTS     = 20;
   localparam int EAS_IDX_W         = 5;
   localparam int EAS_NUM_CMP       = 4;
   localparam int EAS_NUM_LR        = 4;
   localparam int EAS_NUM_STATUS    = 8;
   localparam int EAS_DATA_W        = 16;
   localparam int EAS_SEL_W         = 4;
   localparam int EAS_ACT_W         = 8;
   localparam int EAS_LR_IN_W       = 24;
   localparam logic [EAS_IDX_W-1:0] EAS_FIRST_IDX = 5'h00;
   localparam logic [EAS_IDX_W-1:0] EAS_COUNT_RST = 5'h01;

   // Event source kinds
   typedef enum logic [1:0] {
      EAS_SRC_STATUS = 2'h0,
      EAS_SRC_RULE   = 2'h1,
      EAS_SRC_CMP    = 2'h2,
      EAS_SRC_FALSE  = 2'h3
   } eas_src_type;

   // Comparator operators
   typedef enum logic [2:0] {
      EAS_CMP_LT = 3'h0,
      EAS_CMP_EQ = 3'h1,
      EAS_CMP_GT = 3'h2,
      EAS_CMP_LE = 3'h3,
      EAS_CMP_GE = 3'h4,
      EAS_CMP_NE = 3'h5
   } eas_cmp_op_type;
endpackage

// *** core/eas_comparator.sv ***
// ****************************************************************
// Comparator: operand against preset value
// ****************************************************************
module eas_comparator
   import eas_pkg::*;
#(
   parameter int DATA_W = EAS_DATA_W
) (
   input  wire logic              ref_clk_in,
   input  wire logic              nrst_in,
   input  wire logic [DATA_W-1:0] operand_in,
   input  wire logic [DATA_W-1:0] preset_in,
   input  wire logic [2:0]        op_in,
   output logic                   result_out
);
   wire lt_w = operand_in < preset_in;
   wire eq_w = operand_in == preset_in;
   logic next_result;

   // Operator decode; unknown codes give false
   always_comb begin
      case (op_in)
         EAS_CMP_LT: next_result = lt_w;               // R7
         EAS_CMP_EQ: next_result = eq_w;
         EAS_CMP_GT: next_result = !lt_w && !eq_w;
         EAS_CMP_LE: next_result = lt_w || eq_w;
         EAS_CMP_GE: next_result = !lt_w;
         EAS_CMP_NE: next_result = !eq_w;
         default:    next_result = 1'b0;
      endcase
   end

   // Registered every cycle, so valid outside the sequence too
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         result_out <= 1'b0;
      end else begin
         result_out <= next_result;                    // R10
      end
   end
endmodule

// *** core/eas_logic_rule.sv ***
// ****************************************************************
// Logic rule: three inputs, two operators, optional inversions
// ****************************************************************
module eas_logic_rule (
   input  wire logic       ref_clk_in,
   input  wire logic       nrst_in,
   input  wire logic [2:0] bool_in,
   input  wire logic [2:0] invert_in,
   input  wire logic [1:0] use_or_in,
   input  wire logic       use_third_in,
   output logic            result_out
);
   wire [2:0] term_w   = bool_in ^ invert_in;                // R8
   wire       first_w  = use_or_in[0] ? (term_w[0] | term_w[1])
                                      : (term_w[0] & term_w[1]);
   wire       second_w = use_or_in[1] ? (first_w | term_w[2])
                                      : (first_w & term_w[2]);
   wire       next_w   = use_third_in ? second_w : first_w;  // R8

   // Always evaluated, free for use by other functions
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         result_out <= 1'b0;
      end else begin
         result_out <= next_w;                               // R10
      end
   end
endmodule

// *** core/eas_sequencer.sv ***
// ****************************************************************
// Event/action sequencer top
// ****************************************************************
module eas_sequencer
   import eas_pkg::*;
#(
   parameter int NUM_CMP = EAS_NUM_CMP,
   parameter int NUM_LR  = EAS_NUM_LR,
   parameter int DATA_W  = EAS_DATA_W
) (
   input  wire logic                             ref_clk_in,
   input  wire logic                             nrst_in,
   input  wire logic                             enable_in,
   input  wire logic                             clear_in,
   input  wire logic                             scan_tick_in,
   input  wire logic [EAS_IDX_W-1:0]             pair_count_in,
   input  wire logic [EAS_NUM_STATUS-1:0]        status_in,
   input  wire logic [EAS_MAX_SLOTS*2-1:0]       event_kind_in,
   input  wire logic [EAS_MAX_SLOTS*EAS_SEL_W-1:0] event_sel_in,
   input  wire logic [EAS_MAX_SLOTS*EAS_ACT_W-1:0] action_code_in,
   input  wire logic [NUM_CMP*DATA_W-1:0]        cmp_operand_in,
   input  wire logic [NUM_CMP*DATA_W-1:0]        cmp_preset_in,
   input  wire logic [NUM_CMP*3-1:0]             cmp_op_in,
   input  wire logic [NUM_LR*3-1:0]              lr_invert_in,
   input  wire logic [NUM_LR*2-1:0]              lr_use_or_in,
   input  wire logic [NUM_LR-1:0]                lr_use_third_in,
   input  wire logic [NUM_LR*3*EAS_SEL_W-1:0]    lr_input_sel_in,
   input  wire logic [7:0]                       lr_ext_in,
   output logic [EAS_IDX_W-1:0]                  current_index_out,
   output logic                                  action_strobe_out,
   output logic [EAS_ACT_W-1:0]                  action_code_out,
   output logic [EAS_IDX_W-1:0]                  action_index_out,
   output logic [NUM_CMP-1:0]                    cmp_result_out,
   output logic [NUM_LR-1:0]                     lr_result_out
);
   // ****************************************************************
   // Input synchronisers for pin-level inputs
   // ****************************************************************
   logic [EAS_NUM_STATUS-1:0] status_s1;
   logic [EAS_NUM_STATUS-1:0] status_s2;
   logic [7:0]                ext_s1;
   logic [7:0]                ext_s2;

   // Two flops before any logic reads the status and digital pins
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         status_s1 <= '0;
         status_s2 <= '0;
         ext_s1    <= '0;
         ext_s2    <= '0;
      end else begin
         status_s1 <= status_in;
         status_s2 <= status_s1;
         ext_s1    <= lr_ext_in;
         ext_s2    <= ext_s1;
      end
   end

   // ****************************************************************
   // Comparators and logic rules
   // ****************************************************************
   logic [NUM_CMP-1:0] cmp_res;
   logic [NUM_LR-1:0]  lr_res;
   logic [EAS_IDX_W-1:0] idx;
   logic                 fired;

   // Boolean pool for logic rule inputs: status, comparators, ext, last event
   localparam int POOL_W = 16;
   wire [POOL_W-1:0] pool_w = {fired, 3'h0, cmp_res[3:0], ext_s2[3:0], status_s2[3:0]};

   genvar g;
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_cmp
         eas_comparator #(.DATA_W(DATA_W)) u_cmp (
            .ref_clk_in (ref_clk_in),
            .nrst_in    (nrst_in),
            .operand_in (cmp_operand_in[g*DATA_W +: DATA_W]),
            .preset_in  (cmp_preset_in[g*DATA_W +: DATA_W]),
            .op_in      (cmp_op_in[g*3 +: 3]),
            .result_out (cmp_res[g])
         );
      end
      for (g = 0; g < NUM_LR; g++) begin : g_lr
         wire [EAS_SEL_W-1:0] s0_w = lr_input_sel_in[(g*3+0)*EAS_SEL_W +: EAS_SEL_W];
         wire [EAS_SEL_W-1:0] s1_w = lr_input_sel_in[(g*3+1)*EAS_SEL_W +: EAS_SEL_W];
         wire [EAS_SEL_W-1:0] s2_w = lr_input_sel_in[(g*3+2)*EAS_SEL_W +: EAS_SEL_W];
         eas_logic_rule u_lr (
            .ref_clk_in   (ref_clk_in),
            .nrst_in      (nrst_in),
            .bool_in      ({pool_w[s2_w], pool_w[s1_w], pool_w[s0_w]}), // R8
            .invert_in    (lr_invert_in[g*3 +: 3]),
            .use_or_in    (lr_use_or_in[g*2 +: 2]),
            .use_third_in (lr_use_third_in[g]),
            .result_out   (lr_res[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Event selection at the current index only
   // ****************************************************************
   wire [1:0]           kind_w = event_kind_in[idx*2 +: 2];                  // R2
   wire [EAS_SEL_W-1:0] sel_w  = event_sel_in[idx*EAS_SEL_W +: EAS_SEL_W];   // R2
   wire [EAS_ACT_W-1:0] act_w  = action_code_in[idx*EAS_ACT_W +: EAS_ACT_W]; // R1
   wire stat_hit_w = (sel_w < EAS_NUM_STATUS) ? status_s2[sel_w[2:0]] : 1'b0;
   wire rule_hit_w = (sel_w < NUM_LR) ? lr_res[sel_w[1:0]] : 1'b0;
   wire cmp_hit_w  = (sel_w < NUM_CMP) ? cmp_res[sel_w[1:0]] : 1'b0;
   wire event_true_w = (kind_w == EAS_SRC_STATUS) ? stat_hit_w :           // R9
                       (kind_w == EAS_SRC_RULE)   ? rule_hit_w :           // R9
                       (kind_w == EAS_SRC_CMP)    ? cmp_hit_w  : 1'b0;     // R9

   // Pair count clamped to 1..20 so a bad setting cannot run off the table
   wire [EAS_IDX_W-1:0] count_w = (pair_count_in == 5'h00) ? EAS_COUNT_RST :
                                  (pair_count_in > EAS_IDX_W'(EAS_MAX_SLOTS)) ?
                                  EAS_IDX_W'(EAS_MAX_SLOTS) : pair_count_in;    // R5
   wire last_w   = (idx >= count_w - EAS_COUNT_RST);                       // R5
   wire eval_w   = enable_in && scan_tick_in;                              // R11
   wire hit_w    = eval_w && event_true_w;                                 // R3
   wire [EAS_IDX_W-1:0] next_idx = clear_in ? EAS_FIRST_IDX :               // R11
                                   !hit_w   ? idx :                         // R3
                                   last_w   ? EAS_FIRST_IDX :               // R6
                                   idx + EAS_COUNT_RST;                     // R1

   // Index and action registers
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         idx             <= EAS_FIRST_IDX;                                  // R4
         fired           <= 1'b0;
         action_code_out <= '0;
         action_index_out <= '0;
      end else begin
         idx   <= next_idx;
         fired <= hit_w && !clear_in;
         if (hit_w && !clear_in) begin
            action_code_out  <= act_w;                                      // R1
            action_index_out <= idx;
         end
      end
   end

   // Output mirrors, straight from flops
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         current_index_out <= EAS_FIRST_IDX;
         action_strobe_out <= 1'b0;
         cmp_result_out    <= '0;
         lr_result_out     <= '0;
      end else begin
         current_index_out <= next_idx;
         action_strobe_out <= hit_w && !clear_in;
         cmp_result_out    <= cmp_res;                                      // R10
         lr_result_out     <= lr_res;                                       // R10
      end
   end
endmodule

// *** tb/eas_sequencer_monitor.sv ***
// ****************************************
// Port checker for the sequencer
// ****************************************
module eas_sequencer_monitor
   import eas_pkg::*;
#(
   parameter int NUM_CMP = EAS_NUM_CMP,
   parameter int NUM_LR  = EAS_NUM_LR,
   parameter int DATA_W  = EAS_DATA_W
) (
   input wire logic                       ref_clk_in,
   input wire logic                       nrst_in,
   input wire logic                       enable_in,
   input wire logic                       clear_in,
   input wire logic                       scan_tick_in,
   input wire logic [EAS_IDX_W-1:0]       pair_count_in,
   input wire logic [EAS_MAX_SLOTS*2-1:0] event_kind_in,
   input wire logic [159:0]               action_code_in,
   input wire logic [NUM_CMP*DATA_W-1:0]  cmp_operand_in,
   input wire logic [NUM_CMP*DATA_W-1:0]  cmp_preset_in,
   input wire logic [NUM_CMP*3-1:0]       cmp_op_in,
   input wire logic [EAS_IDX_W-1:0]       current_index_out,
   input wire logic                       action_strobe_out,
   input wire logic [EAS_ACT_W-1:0]       action_code_out,
   input wire logic [EAS_IDX_W-1:0]       action_index_out,
   input wire logic [NUM_CMP-1:0]         cmp_result_out
);
   wire logic [4:0] cnt_c;
   wire logic [4:0] next_idx;
   // Clamped count, so a zero or oversize setting cannot hide a bad wrap
   assign cnt_c = (pair_count_in == 5'h00) ? 5'h01 :
                  (pair_count_in > 5'h14) ? 5'h14 : pair_count_in;
   assign next_idx = (action_index_out + 5'h01 == cnt_c) ? 5'h00 : action_index_out + 5'h01;
   // All checks live in the one clock domain
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   tick_cause_a: assert property (action_strobe_out |-> $past(scan_tick_in & enable_in & ~clear_in))
      else $error("action without a qualified scan tick");
   idle_hold_a: assert property (!action_strobe_out && !$past(clear_in) |-> $stable(current_index_out))
      else $error("index moved without an action");
   advance_wrap_a: assert property (action_strobe_out |-> current_index_out == next_idx)
      else $error("index did not step or wrap after action");
   code_pair_a: assert property (action_strobe_out |-> action_code_out == action_code_in[action_index_out*8 +: 8])
      else $error("action code not from the fired slot");
   index_range_a: assert property (current_index_out < cnt_c)
      else $error("index beyond configured slots");
   clear_wins_a: assert property (clear_in |=> current_index_out == 5'h00 && !action_strobe_out)
      else $error("clear did not return index to first slot");
   source_live_a: assert property (action_strobe_out |-> event_kind_in[action_index_out*2 +: 2] != EAS_SRC_FALSE)
      else $error("action fired from a never-true source");
   // Two flops deep: the comparator register, then the output mirror
   cmp_equal_a: assert property ($past(cmp_op_in[2:0], 2) == 3'h1 |-> cmp_result_out[0] ==
         ($past(cmp_operand_in[DATA_W-1:0], 2) == $past(cmp_preset_in[DATA_W-1:0], 2)))
      else $error("equality comparator result wrong");
endmodule

bind eas_sequencer eas_sequencer_monitor #(.NUM_CMP(NUM_CMP), .NUM_LR(NUM_LR), .DATA_W(DATA_W))
   eas_sequencer_monitor_i (.ref_clk_in, .nrst_in, .enable_in, .clear_in, .scan_tick_in,
   .pair_count_in, .event_kind_in, .action_code_in, .cmp_operand_in, .cmp_preset_in,
   .cmp_op_in, .current_index_out, .action_strobe_out, .action_code_out,
   .action_index_out, .cmp_result_out);

// *** tb/eas_sequencer_tb_top.sv ***
module eas_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic         ref_clk_in = 1'b0;
   logic         nrst_in = 1'b0;
   logic         enable_in = 1'b1;
   logic         clear_in = 1'b0;
   logic         scan_tick_in = 1'b0;
   logic [4:0]   pair_count_in = 5'h01;
   logic [7:0]   status_in = 8'h00;
   logic [7:0]   lr_ext_in = 8'h00;
   logic [39:0]  event_kind_in = 40'h0;
   logic [79:0]  event_sel_in = 80'h0;
   logic [159:0] action_code_in = 160'h0;
   logic [63:0]  cmp_operand_in = 64'h0;
   logic [63:0]  cmp_preset_in = 64'h0;
   logic [11:0]  cmp_op_in = 12'h000;
   logic [7:0]   lr_use_or_in = 8'h00;
   logic [3:0]   lr_use_third_in = 4'h0;
   logic [11:0]  lr_invert_in = 12'h000;
   // Rules 0 to 2 read status 0, 1, 2; rule 3 reads comparator 0, digital 1, status 3
   logic [47:0]  lr_input_sel_in = 48'h358210210210;
   logic [4:0]   current_index_out, action_index_out, exp_idx;
   logic         action_strobe_out;
   logic [7:0]   action_code_out;
   logic [3:0]   cmp_result_out, lr_result_out;
   int           fails = 0, checked = 0, cnt = 1;
   int           seed = 32'h0d5b55e5;
   // Block plan: single slot, full twenty, mixed, never-true, zero and oversize counts
   logic [4:0]   blk_count [6] = '{5'h01, 5'h14, 5'h07, 5'h03, 5'h00, 5'h1f};
   logic [39:0]  blk_mask [6] = '{40'hffffffffff, 40'h0, 40'hffffffffff, 40'h0,
                                  40'hffffffffff, 40'h0};
   logic [39:0]  blk_force [6] = '{40'h0, 40'h0, 40'h0, 40'hffffffffff, 40'h0, 40'h0};
   int           blk_steps [6] = '{40, 90, 60, 20, 20, 60};

   // Rule inversions are random, input selections fixed
   eas_sequencer eas_sequencer_i (
      .ref_clk_in, .nrst_in, .enable_in, .clear_in, .scan_tick_in, .pair_count_in,
      .status_in, .event_kind_in, .event_sel_in, .action_code_in, .cmp_operand_in,
      .cmp_preset_in, .cmp_op_in, .lr_invert_in, .lr_use_or_in,
      .lr_use_third_in, .lr_input_sel_in, .lr_ext_in,
      .current_index_out, .action_strobe_out, .action_code_out, .action_index_out,
      .cmp_result_out, .lr_result_out);

   // Clock, 100 ns period
   always #50 ref_clk_in = ~ref_clk_in;

   // ****************************************
   // Expectation functions
   // ****************************************
   function automatic logic cmp_fn(input int c);
      logic [15:0] a, b;
      a = cmp_operand_in[c*16 +: 16];
      b = cmp_preset_in[c*16 +: 16];
      case (cmp_op_in[c*3 +: 3])
         3'h0: return a < b;
         3'h1: return a == b;
         3'h2: return a > b;
         3'h3: return a <= b;
         3'h4: return a >= b;
         3'h5: return a != b;
         default: return 1'b0;
      endcase
   endfunction

   // Pool: status 0-3, digital inputs 4-7, comparators 8-11, rest unused here
   function automatic logic pool_fn(input int p);
      if (p < 4) return status_in[p];
      else if (p < 8) return lr_ext_in[p-4];
      else if (p < 12) return cmp_fn(p-8);
      else return 1'b0;
   endfunction

   function automatic logic rule_fn(input int r);
      logic [2:0] t;
      logic       x;
      for (int k = 0; k < 3; k++) begin
         t[k] = pool_fn(lr_input_sel_in[(r*3+k)*4 +: 4]) ^ lr_invert_in[r*3+k];
      end
      x = lr_use_or_in[2*r] ? (t[0] | t[1]) : (t[0] & t[1]);
      if (lr_use_third_in[r]) x = lr_use_or_in[2*r+1] ? (x | t[2]) : (x & t[2]);
      return x;
   endfunction

   function automatic logic ev_fn(input int i);
      logic [3:0] s;
      s = event_sel_in[i*4 +: 4];
      case (event_kind_in[i*2 +: 2])
         2'h0: return (s < 4'h8) ? status_in[s[2:0]] : 1'b0;
         2'h1: return (s < 4'h4) ? rule_fn(s) : 1'b0;
         2'h2: return (s < 4'h4) ? cmp_fn(s) : 1'b0;
         default: return 1'b0;
      endcase
   endfunction

   // ****************************************
   // Drivers and comparison
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic config_block(input logic [4:0] pc, input logic [39:0] km, input logic [39:0] ko);
      // Clear first, so a shorter count never meets an index beyond it
      @(posedge ref_clk_in);
      clear_in       <= 1'b1;
      @(posedge ref_clk_in);
      pair_count_in  <= pc;
      event_kind_in  <= (40'({$random(seed), $random(seed)}) & km) | ko;
      event_sel_in   <= 80'({$random(seed), $random(seed), $random(seed)}) & {20{4'h7}};
      action_code_in <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge ref_clk_in);
      clear_in <= 1'b0;
      // Zero counts as one slot, anything above twenty as twenty
      cnt = (pc == 5'h00) ? 1 : (pc > 5'h14) ? 20 : int'(pc);
      exp_idx = 5'h00;
      #1 check(current_index_out, 8'h00);
   endtask

   // Sources settle four cycles first: two sync flops, the result register and the output mirror
   task automatic tick_step(input logic en, input logic clr);
      logic       ev;
      logic [4:0] old;
      @(posedge ref_clk_in);
      status_in       <= 8'($random(seed));
      lr_ext_in       <= 8'($random(seed));
      cmp_operand_in  <= {$random(seed), $random(seed)} & {4{16'h0003}};
      cmp_preset_in   <= {$random(seed), $random(seed)} & {4{16'h0003}};
      cmp_op_in       <= 12'($random(seed));
      lr_use_or_in    <= 8'($random(seed));
      lr_use_third_in <= 4'($random(seed));
      lr_invert_in    <= 12'($random(seed));
      repeat (4) @(posedge ref_clk_in);
      #1;
      for (int k = 0; k < 4; k++) begin
         check(cmp_result_out[k], cmp_fn(k));
         check(lr_result_out[k], rule_fn(k));
      end
      ev = en & ~clr & ev_fn(exp_idx);
      @(posedge ref_clk_in);
      enable_in    <= en;
      clear_in     <= clr;
      scan_tick_in <= 1'b1;
      @(posedge ref_clk_in);
      scan_tick_in <= 1'b0;
      enable_in    <= 1'b1;
      clear_in     <= 1'b0;
      #1 check(action_strobe_out, ev);
      old = exp_idx;
      if (clr) exp_idx = 5'h00;
      else if (ev) exp_idx = (exp_idx == cnt - 1) ? 5'h00 : exp_idx + 5'h01;
      check(current_index_out, exp_idx);
      if (ev) begin
         check(action_code_out, action_code_in[old*8 +: 8]);
         check(action_index_out, old);
      end
      @(posedge ref_clk_in);
      #1 check(action_strobe_out, 8'h00);
   endtask

   task automatic finish_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (6) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      for (int b = 0; b < 6; b++) begin
         config_block(blk_count[b], blk_mask[b], blk_force[b]);
         repeat (blk_steps[b]) tick_step($random(seed) % 8 != 0, $random(seed) % 16 == 0);
         $display("block %0d done", b);
      end
      // Reset in mid-run must drop index, strobe and action outputs at once
      @(posedge ref_clk_in);
      nrst_in <= 1'b0;
      @(posedge ref_clk_in);
      #1 check({action_strobe_out, current_index_out}, 8'h00);
      check(action_code_out, 8'h00);
      check(action_index_out, 8'h00);
      // Release and run again from slot zero, as on a first start
      @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      exp_idx = 5'h00;
      repeat (8) tick_step(1'b1, 1'b0);
      $display("reset test done");
      finish_test();
   end

   // Budget is about twice the planned run
   initial begin
      #500000;
      fails++;
      finish_test();
   end
endmodule
